/* File: logic/io_image_framer.sv */
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module io_image_framer
    import io_image_pkg::*;
#(
    parameter logic [5:0] MAP_DEFAULT = MAP_SIZE_RST
)(
    input  wire logic                 SYS_CLK_I,          // System clock, 10 MHz
    input  wire logic                 RST_B_I,            // Asynchronous reset, active low
    input  wire logic                 CE_I,               // Clock enable, freezes all state when low
    // Avalon-MM register slave
    input  wire logic [4:0]           AVS_ADDRESS_I,      // Byte address
    input  wire logic                 AVS_READ_I,         // Read request
    input  wire logic                 AVS_WRITE_I,        // Write request
    input  wire logic [31:0]          AVS_WRITEDATA_I,    // Write data
    input  wire logic [3:0]           AVS_BYTEENABLE_I,   // Byte lanes of a write
    output logic      [31:0]          AVS_READDATA_O,     // Read data
    output logic                      AVS_WAITREQUEST_O,  // Stall, high until answer
    // Port pins
    input  wire logic [3:0]           PIN2_DIGITAL_IN_I,  // Pin-2 levels, asynchronous
    input  wire logic [3:0]           CQ_DIGITAL_IN_I,    // C/Q levels, asynchronous
    output logic      [3:0]           CQ_DIGITAL_OUT_O,   // C/Q output levels
    output logic      [3:0]           CQ_OUT_EN_O,        // C/Q driven by this block
    // Port controllers
    input  wire port_stat_s [3:0]     PORT_STAT_I,        // Per-port condition bundle
    input  wire logic                 PD_WE_I,            // Received input byte strobe
    input  wire logic [1:0]           PD_PORT_I,          // Port of received byte
    input  wire logic [4:0]           PD_IDX_I,           // Byte index within port data
    input  wire logic [7:0]           PD_DATA_I,          // Received input byte
    input  wire logic [1:0]           OPD_PORT_I,         // Port of output byte to fetch
    input  wire logic [4:0]           OPD_IDX_I,          // Index of output byte to fetch
    output logic      [7:0]           OPD_DATA_O,         // Fetched output byte, one cycle later
    // Fieldbus side: input image stream
    input  wire logic                 CYCLE_START_I,      // Start one input image, pulse
    output logic                      IMG_VALID_O,        // Image byte valid
    output logic      [7:0]           IMG_DATA_O,         // Image byte
    output logic                      IMG_LAST_O,         // Byte 43 of the image
    input  wire logic                 IMG_READY_I,        // Receiver takes the byte
    // Fieldbus side: output image stream
    input  wire logic                 OIMG_VALID_I,       // Output image byte valid
    input  wire logic [7:0]           OIMG_DATA_I,        // Output image byte
    input  wire logic                 OIMG_LAST_I,        // Final byte of output image
    output logic                      OIMG_READY_O        // Block accepts the byte
);

    // Clamp a mapping size to the per-port maximum
    function automatic logic [5:0] clamp_size(input logic [5:0] sz);
        return (sz > 6'(PORT_PD_MAX)) ? 6'(PORT_PD_MAX) : sz;
    endfunction

    // Map an image byte position onto a port and byte index
    function automatic map_hit_s map_lookup(input logic [5:0] pos, input logic [3:0][5:0] sizes);
        map_hit_s   r;
        logic [6:0] base;
        logic [6:0] rel;
        logic [6:0] sz;
        r    = '0;
        base = 7'h00;
        rel  = 7'(pos) - 7'(PD_FIRST);
        sz   = 7'h00;
        if (pos >= POS_PD_FIRST && pos <= POS_PD_LAST)
        begin
            for (int p = 0; p < PORT_COUNT; p++)
            begin
                sz = 7'(clamp_size(sizes[p]));
                if (!r.hit && rel >= base && rel < base + sz && rel < 7'(PD_REGION))
                begin
                    r.hit  = 1'b1;
                    r.port = 2'(p);
                    r.idx  = 5'(rel - base);
                end
                base = base + sz;
            end
        end
        return r;
    endfunction

    // Build one port status byte
    function automatic logic [7:0] status_byte(input port_stat_s s, input logic [5:0] map_sz);
        logic [7:0] r;
        r = 8'h00;
        r[ST_IDENTITY_MISMATCH_FLAG]  = s.identity_mismatch_flag;
        r[ST_MAP_ERROR]    = (s.actual_pd_len > clamp_size(map_sz));
        r[ST_SUPPLY_SHORT] = s.lplus_short | s.aux_supply_24v_short;
        r[ST_CQ_SHORT]     = s.cq_line_short_flag;
        r[ST_SAVED_VALID]  = s.saved_config_valid_flag;
        r[ST_LINK_ACTIVE]  = s.link_active_flag;
        r[ST_EVENT]        = s.event_pending_flag;
        r[ST_INPUT_VALID]  = s.input_valid_flag;
        return r;
    endfunction

    logic [3:0]       pin2_meta_r;
    logic [3:0]       pin2_sync_r;
    logic [3:0]       cq_meta_r;
    logic [3:0]       cq_sync_r;
    logic [3:0]       in_mode_r;
    logic [3:0]       out_mode_r;
    logic [3:0][5:0]  map_r;
    logic [3:0][7:0]  status_r;
    logic [15:0]      frames_r;
    logic             wait_r;
    logic [7:0]       ipd_mem [0:127];
    logic [7:0]       opd_mem [0:127];
    frame_e           frame_r;
    logic [5:0]       ipos_r;
    logic [5:0]       opos_r;
    img_byte_s        head_r;
    logic             head_v_r;
    img_byte_s        spare_r;
    logic             spare_v_r;
    logic [7:0]       pin_byte;
    img_byte_s        gen_byte;
    map_hit_s         ihit;
    map_hit_s         ohit;
    logic             gen_valid;
    logic             buf_ready;
    logic             pop;
    logic             push;
    logic             bus_req;
    logic [31:0]      reg_rd;

    // Pin synchronisers, two stages before use
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            pin2_meta_r <= 4'h0;
            pin2_sync_r <= 4'h0;
            cq_meta_r   <= 4'h0;
            cq_sync_r   <= 4'h0;
        end
        else if (CE_I)
        begin
            pin2_meta_r <= PIN2_DIGITAL_IN_I;
            pin2_sync_r <= pin2_meta_r;
            cq_meta_r   <= CQ_DIGITAL_IN_I;
            cq_sync_r   <= cq_meta_r;
        end
    end

    // Pin byte of the input image
    always_comb
    begin
        pin_byte = 8'h00;
        for (int p = 0; p < PORT_COUNT; p++)
        begin
            pin_byte[2*p+1] = pin2_sync_r[p];
            pin_byte[2*p]   = cq_sync_r[p] & in_mode_r[p];
        end
    end

    // Status bytes sampled every cycle
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            status_r <= '0;
        else if (CE_I)
            for (int p = 0; p < PORT_COUNT; p++)
                status_r[p] <= status_byte(PORT_STAT_I[p], map_r[p]);
    end

    // Received input process data store
    always_ff @(posedge SYS_CLK_I)
    begin
        if (CE_I && PD_WE_I && PORT_STAT_I[PD_PORT_I].input_valid_flag)
            ipd_mem[{PD_PORT_I, PD_IDX_I}] <= PD_DATA_I;
    end

    // Register bus: decode and read mux
    assign bus_req = AVS_READ_I | AVS_WRITE_I;
    always_comb
    begin
        case (AVS_ADDRESS_I)
            REG_MODE:   reg_rd = {24'h000000, out_mode_r, in_mode_r};
            REG_MAP:    reg_rd = {2'b00, map_r[3], 2'b00, map_r[2], 2'b00, map_r[1], 2'b00, map_r[0]};
            REG_STATUS: reg_rd = status_r;
            REG_PINS:   reg_rd = {24'h000000, pin_byte};
            REG_FRAMES: reg_rd = {16'h0000, frames_r};
            default:    reg_rd = 32'h00000000;
        endcase
    end

    // Waitrequest drops for one cycle; read data captured with it
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            wait_r         <= 1'b1;
            AVS_READDATA_O <= 32'h00000000;
        end
        else if (CE_I)
        begin
            wait_r <= !(bus_req && wait_r);
            if (AVS_READ_I && wait_r)
                AVS_READDATA_O <= reg_rd;
        end
    end
    assign AVS_WAITREQUEST_O = wait_r;

    // Writable registers, committed on the edge the master sees the answer
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            in_mode_r  <= MODE_IN_RST;
            out_mode_r <= MODE_OUT_RST;
            map_r      <= {4{MAP_DEFAULT}};
        end
        else if (CE_I && AVS_WRITE_I && !wait_r)
        begin
            // Mode fields sit in byte lane 0
            if (AVS_ADDRESS_I == REG_MODE && AVS_BYTEENABLE_I[0])
            begin
                in_mode_r  <= AVS_WRITEDATA_I[MODE_IN_LSB +: 4];
                out_mode_r <= AVS_WRITEDATA_I[MODE_OUT_LSB +: 4];
            end
            else if (AVS_ADDRESS_I == REG_MAP)
                for (int p = 0; p < PORT_COUNT; p++)
                    if (AVS_BYTEENABLE_I[p])
                        map_r[p] <= AVS_WRITEDATA_I[p*MAP_STRIDE +: 6];
        end
    end

    // Input image byte generator
    assign ihit      = map_lookup(ipos_r, map_r);
    assign gen_valid = (frame_r == FR_SEND);
    assign buf_ready = !spare_v_r;
    assign push      = gen_valid && buf_ready;
    assign pop       = head_v_r && IMG_READY_I;

    always_comb
    begin
        gen_byte.last = (ipos_r == POS_LAST);
        if (ipos_r == POS_PINS)
            gen_byte.data = pin_byte;
        else if (ipos_r == POS_RSVD)
            gen_byte.data = 8'h00;
        else if (ihit.hit)
            gen_byte.data = ipd_mem[{ihit.port, ihit.idx}];
        else if (ipos_r >= POS_STAT_FIRST && ipos_r <= POS_LAST)
            gen_byte.data = status_r[2'(ipos_r - POS_STAT_FIRST)];
        else
            gen_byte.data = 8'h00;
    end

    // Frame sequencer: 44 bytes per start, stalls with the buffer
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            frame_r  <= FR_IDLE;
            ipos_r   <= 6'h00;
            frames_r <= 16'h0000;
        end
        else if (CE_I)
        begin
            case (frame_r)
                FR_IDLE:
                begin
                    ipos_r <= 6'h00;
                    if (CYCLE_START_I)
                        frame_r <= FR_SEND;
                end
                // 44-byte image, counted as its last byte is buffered
                FR_SEND:
                    if (push && ipos_r == POS_LAST)
                    begin
                        frame_r  <= FR_IDLE;
                        frames_r <= frames_r + 16'h0001;
                    end
                    else if (push)
                        ipos_r <= ipos_r + 6'h01;
                default:
                    frame_r <= FR_IDLE;
            endcase
        end
    end

    // Two-entry buffer toward the fieldbus receiver
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            head_r    <= '0;
            head_v_r  <= 1'b0;
            spare_r   <= '0;
            spare_v_r <= 1'b0;
        end
        else if (CE_I)
        begin
            // Pop refills the head from the spare first; push never meets a full spare
            if (pop)
            begin
                head_r    <= spare_v_r ? spare_r : gen_byte;
                head_v_r  <= spare_v_r | push;
                spare_v_r <= 1'b0;
            end
            else if (push && head_v_r)
            begin
                spare_r   <= gen_byte;
                spare_v_r <= 1'b1;
            end
            else if (push)
            begin
                head_r   <= gen_byte;
                head_v_r <= 1'b1;
            end
        end
    end

    assign IMG_VALID_O = head_v_r;
    assign IMG_DATA_O  = head_r.data;
    assign IMG_LAST_O  = head_r.last;

    // Output image decoder
    assign ohit = map_lookup(opos_r, map_r);
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            opos_r           <= 6'h00;
            OIMG_READY_O     <= 1'b0;
            CQ_DIGITAL_OUT_O <= 4'h0;
            CQ_OUT_EN_O      <= 4'h0;
        end
        else if (CE_I)
        begin
            OIMG_READY_O <= 1'b1;
            CQ_OUT_EN_O  <= out_mode_r;
            if (OIMG_VALID_I && OIMG_READY_O)
                opos_r <= (OIMG_LAST_I || opos_r == POS_LAST) ? 6'h00 : opos_r + 6'h01;
            // lower bit of each pair; masked every edge so a mode drop clears the pin
            if (OIMG_VALID_I && OIMG_READY_O && opos_r == POS_PINS)
                CQ_DIGITAL_OUT_O <= {OIMG_DATA_I[6], OIMG_DATA_I[4], OIMG_DATA_I[2], OIMG_DATA_I[0]} & out_mode_r;
            else
                CQ_DIGITAL_OUT_O <= CQ_DIGITAL_OUT_O & out_mode_r;
        end
    end

    // Output process data store; byte 1, status tail and unassigned bytes dropped
    always_ff @(posedge SYS_CLK_I)
    begin
        if (CE_I && OIMG_VALID_I && OIMG_READY_O && ohit.hit)
            opd_mem[{ohit.port, ohit.idx}] <= OIMG_DATA_I;
    end

    // Output data fetch for the port controllers
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            OPD_DATA_O <= 8'h00;
        else if (CE_I)
            OPD_DATA_O <= opd_mem[{OPD_PORT_I, OPD_IDX_I}];
    end

endmodule // io_image_framer

/* File: logic/io_image_pkg.sv */
package io_image_pkg;

    // Image geometry
    localparam int unsigned IMG_BYTES     = 44;
    localparam int unsigned PD_FIRST      = 2;
    localparam int unsigned PD_LAST       = 39;
    localparam int unsigned PD_REGION     = 38;
    localparam int unsigned STATUS_FIRST  = 40;
    localparam int unsigned PORT_COUNT    = 4;
    localparam int unsigned PORT_PD_MAX   = 32;

    // Image byte positions
    localparam logic [5:0] POS_PINS       = 6'h00;
    localparam logic [5:0] POS_RSVD       = 6'h01;
    localparam logic [5:0] POS_PD_FIRST   = 6'h02;
    localparam logic [5:0] POS_PD_LAST    = 6'h27;
    localparam logic [5:0] POS_STAT_FIRST = 6'h28;
    localparam logic [5:0] POS_LAST       = 6'h2b;

    // Status byte bit positions
    localparam int unsigned ST_IDENTITY_MISMATCH_FLAG = 0;
    localparam int unsigned ST_MAP_ERROR   = 1;
    localparam int unsigned ST_SUPPLY_SHORT = 2;
    localparam int unsigned ST_CQ_SHORT    = 3;
    localparam int unsigned ST_SAVED_VALID = 4;
    localparam int unsigned ST_LINK_ACTIVE = 5;
    localparam int unsigned ST_EVENT       = 6;
    localparam int unsigned ST_INPUT_VALID = 7;

    // Register byte offsets
    localparam logic [4:0] REG_MODE       = 5'h00;
    localparam logic [4:0] REG_MAP        = 5'h04;
    localparam logic [4:0] REG_STATUS     = 5'h08;
    localparam logic [4:0] REG_PINS       = 5'h0c;
    localparam logic [4:0] REG_FRAMES     = 5'h10;

    // Field positions: mode register and mapping register
    localparam int unsigned MODE_IN_LSB   = 0;
    localparam int unsigned MODE_OUT_LSB  = 4;
    localparam int unsigned MAP_STRIDE    = 8;

    // Reset values
    localparam logic [3:0]  MODE_IN_RST   = 4'h0;
    localparam logic [3:0]  MODE_OUT_RST  = 4'h0;
    localparam logic [5:0]  MAP_SIZE_RST  = 6'h02;

    // Per-port condition bundle from the port controllers
    typedef struct packed {
        logic       input_valid_flag;
        logic       event_pending_flag;
        logic       link_active_flag;
        logic       saved_config_valid_flag;
        logic       cq_line_short_flag;
        logic       aux_supply_24v_short;
        logic       lplus_short;
        logic       identity_mismatch_flag;
        logic [5:0] actual_pd_len;
    } port_stat_s;

    // Result of mapping an image byte onto a port
    typedef struct packed {
        logic       hit;
        logic [1:0] port;
        logic [4:0] idx;
    } map_hit_s;

    // One byte of a streamed image
    typedef struct packed {
        logic       last;
        logic [7:0] data;
    } img_byte_s;

    typedef enum logic {
        FR_IDLE = 1'b0,
        FR_SEND = 1'b1
    } frame_e;

endpackage

/* File: verif/io_image_chk.sv */
`timescale 1ns/1ps
module io_image_chk
    import io_image_pkg::*;
(
    input  wire logic             SYS_CLK_I,         // Clock
    input  wire logic             RST_B_I,           // Reset
    input  wire logic [3:0]       PIN2_DIGITAL_IN_I, // Pin-2 levels
    input  wire logic [3:0]       CQ_DIGITAL_OUT_O,  // C/Q out
    input  wire logic [3:0]       CQ_OUT_EN_O,       // C/Q enable
    input  wire port_stat_s [3:0] PORT_STAT_I,       // Conditions
    input  wire logic             IMG_VALID_O,       // In stream
    input  wire logic [7:0]       IMG_DATA_O,        // In byte
    input  wire logic             IMG_LAST_O,        // In last
    input  wire logic             IMG_READY_I,       // In ready
    input  wire logic             OIMG_VALID_I,      // Out stream
    input  wire logic [7:0]       OIMG_DATA_I,       // Out byte
    input  wire logic             OIMG_LAST_I,       // Out last
    input  wire logic             OIMG_READY_O       // Out ready
);
    logic [5:0] pos_r;
    logic [5:0] opos_r;
    port_stat_s st;
    logic [3:0] ohead;
    assign st = PORT_STAT_I[pos_r[1:0]];
    assign ohead = {OIMG_DATA_I[6], OIMG_DATA_I[4], OIMG_DATA_I[2], OIMG_DATA_I[0]};
    // Position of the next input image byte
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
        if (!RST_B_I) pos_r <= 6'h00;
        else if (IMG_VALID_O && IMG_READY_I) pos_r <= IMG_LAST_O ? 6'h00 : pos_r + 6'h01;
    // Position of the next output image byte
    always_ff @(posedge SYS_CLK_I or negedge RST_B_I)
        if (!RST_B_I) opos_r <= 6'h00;
        else if (OIMG_VALID_I && OIMG_READY_O) opos_r <= (OIMG_LAST_I || opos_r == 6'h2b) ? 6'h00 : opos_r + 6'h01;
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RST_B_I);
    sequence s_pins_quiet;
        $stable(PIN2_DIGITAL_IN_I) [*8];
    endsequence
    sequence s_head_take;
        OIMG_VALID_I && OIMG_READY_O && opos_r == 6'h00 && $stable(CQ_OUT_EN_O);
    endsequence
    a_byte_one_zero: assert property (
        IMG_VALID_O && pos_r == 6'h01 |-> IMG_DATA_O == 8'h00) else $error("byte 1 not zero");
    a_last_at_end: assert property (
        IMG_VALID_O |-> IMG_LAST_O == (pos_r == 6'h2b)) else $error("last flag misplaced");
    a_pin2_bits: assert property (
        s_pins_quiet ##0 (IMG_VALID_O && pos_r == 6'h00) |->
        {IMG_DATA_O[7], IMG_DATA_O[5], IMG_DATA_O[3], IMG_DATA_O[1]} == PIN2_DIGITAL_IN_I)
        else $error("pin-2 bits wrong");
    a_idmis_bit: assert property (
        IMG_VALID_O && pos_r >= 6'h28 |-> IMG_DATA_O[0] == st.identity_mismatch_flag)
        else $error("identity bit wrong");
    a_short_bits: assert property (
        IMG_VALID_O && pos_r >= 6'h28 |->
        IMG_DATA_O[3:2] == {st.cq_line_short_flag, st.aux_supply_24v_short | st.lplus_short})
        else $error("short bits wrong");
    a_state_flags: assert property (
        IMG_VALID_O && pos_r >= 6'h28 |-> IMG_DATA_O[7:4] == {st.input_valid_flag,
        st.event_pending_flag, st.link_active_flag, st.saved_config_valid_flag})
        else $error("status flags wrong");
    a_cq_enabled: assert property (
        (CQ_DIGITAL_OUT_O & ~CQ_OUT_EN_O) == 4'h0) else $error("C/Q driven without mode");
    a_cq_follow: assert property (
        s_head_take |=> CQ_DIGITAL_OUT_O == ($past(ohead) & CQ_OUT_EN_O)) else $error("C/Q out wrong");
    a_stream_hold: assert property (
        IMG_VALID_O && !IMG_READY_I |=> IMG_VALID_O && $stable(IMG_DATA_O) && $stable(IMG_LAST_O))
        else $error("stalled byte changed");
endmodule // io_image_chk
bind io_image_framer io_image_chk i_chk (.SYS_CLK_I, .RST_B_I, .PIN2_DIGITAL_IN_I, .CQ_DIGITAL_OUT_O,
    .CQ_OUT_EN_O, .PORT_STAT_I, .IMG_VALID_O, .IMG_DATA_O, .IMG_LAST_O, .IMG_READY_I, .OIMG_VALID_I,
    .OIMG_DATA_I, .OIMG_LAST_I, .OIMG_READY_O);

/* File: verif/fieldbus_model.sv */
`timescale 1ns/1ps
module fieldbus_model
    import io_image_pkg::*;
(
    input  wire logic      clk_i,        // Clock
    input  wire logic      rst_b_i,      // Reset
    input  wire logic      stall_i,      // Throttle input image
    input  wire logic      go_i,         // Send output image
    input  wire img_byte_s img_i,        // Input image byte
    input  wire logic      img_valid_i,  // Input byte valid
    output logic           img_ready_o,  // Input byte taken
    output img_byte_s      oimg_o,       // Output image byte
    output logic           oimg_valid_o, // Output byte valid
    input  wire logic      oimg_ready_i  // Output byte taken
);
    logic [7:0] rx [44];
    logic [7:0] tx [44];
    logic [5:0] rx_n;
    logic [5:0] tx_n;
    logic [1:0] ph;
    int         frames;
    // Collect input image, ready one cycle in four when throttled
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            img_ready_o <= 1'b0;
            rx_n <= 6'h00;
            ph <= 2'h0;
            frames <= 0;
        end
        else
        begin
            ph <= ph + 2'h1;
            img_ready_o <= !stall_i || ph == 2'h3;
            if (img_valid_i && img_ready_o)
            begin
                rx[rx_n] <= img_i.data;
                rx_n <= img_i.last ? 6'h00 : rx_n + 6'h01;
                if (img_i.last) frames <= frames + 1;
            end
        end
    // Send output image, inverted data once released
    always_ff @(posedge clk_i or negedge rst_b_i)
        if (!rst_b_i)
        begin
            oimg_valid_o <= 1'b0;
            oimg_o <= '0;
            tx_n <= 6'h00;
        end
        else if (oimg_valid_o && oimg_ready_i)
        begin
            oimg_valid_o <= tx_n != 6'h2b;
            oimg_o <= (tx_n == 6'h2b) ? ~oimg_o : {tx_n == 6'h2a, tx[tx_n + 6'h01]};
            tx_n <= tx_n + 6'h01;
        end
        else if (go_i && !oimg_valid_o)
        begin
            oimg_valid_o <= 1'b1;
            oimg_o <= {1'b0, tx[0]};
            tx_n <= 6'h00;
        end
endmodule // fieldbus_model

/* File: verif/test_io_link_master_io_image.sv */
`timescale 1ns/1ps
module test_io_link_master_io_image
    import io_image_pkg::*;
;
    logic clk = 0, rst_b = 0, rd = 0, wr = 0, start = 0, stall = 0, go = 0, pd_we = 0;
    logic [4:0] addr = '0, pd_idx = '0, opd_idx = '0;
    logic [31:0] wdata = '0, rdata_w, rword;
    logic [1:0] pd_port = '0, opd_port = '0;
    logic [7:0] pd_data = '0, opd_w, id_w;
    logic [3:0] pin2 = '0, cq = '0, mode_in, cqo_w, cqe_w;
    logic wait_w, iv_w, il_w, ir_w, ov_w, or_w;
    port_stat_s [3:0] stat = '0;
    img_byte_s oimg_w;
    logic [7:0] pd [4][32];
    logic [7:0] ex [44];
    int msz [4];
    int error_cnt = 0, cmp_count = 0;
    // Clock
    always #50 clk = ~clk;
    io_image_framer i_dut (.SYS_CLK_I(clk), .RST_B_I(rst_b), .CE_I(1'b1), .AVS_ADDRESS_I(addr),
        .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hf),
        .AVS_READDATA_O(rdata_w), .AVS_WAITREQUEST_O(wait_w), .PIN2_DIGITAL_IN_I(pin2),
        .CQ_DIGITAL_IN_I(cq), .CQ_DIGITAL_OUT_O(cqo_w), .CQ_OUT_EN_O(cqe_w), .PORT_STAT_I(stat),
        .PD_WE_I(pd_we), .PD_PORT_I(pd_port), .PD_IDX_I(pd_idx), .PD_DATA_I(pd_data),
        .OPD_PORT_I(opd_port), .OPD_IDX_I(opd_idx), .OPD_DATA_O(opd_w), .CYCLE_START_I(start),
        .IMG_VALID_O(iv_w), .IMG_DATA_O(id_w), .IMG_LAST_O(il_w), .IMG_READY_I(ir_w),
        .OIMG_VALID_I(ov_w), .OIMG_DATA_I(oimg_w.data), .OIMG_LAST_I(oimg_w.last), .OIMG_READY_O(or_w));
    fieldbus_model i_fb (.clk_i(clk), .rst_b_i(rst_b), .stall_i(stall), .go_i(go), .img_i({il_w, id_w}),
        .img_valid_i(iv_w), .img_ready_o(ir_w), .oimg_o(oimg_w), .oimg_valid_o(ov_w), .oimg_ready_i(or_w));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("mismatches %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tmo;
        error_cnt++;
        $display("MISMATCH %0t timeout", $time);
        close_out;
    endtask
    // Avalon-MM access, held until waitrequest low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_w !== 1'b0 && n < 50);
        if (n >= 50) tmo;
        rword = rdata_w;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic pdw(input logic [1:0] p, input logic [4:0] i, input logic [7:0] d);
        @(posedge clk);
        pd_we <= 1'b1;
        pd_port <= p;
        pd_idx <= i;
        pd_data <= d;
        @(posedge clk);
        pd_we <= 1'b0;
    endtask
    task automatic opd(input logic [1:0] p, input logic [4:0] i, input logic [7:0] e);
        @(posedge clk);
        opd_port <= p;
        opd_idx <= i;
        repeat (2) @(posedge clk);
        chk(opd_w, e);
    endtask
    // Expected input image from pins, mode, data and conditions
    task automatic build;
        int b;
        b = 2;
        foreach (ex[k]) ex[k] = 8'h00;
        for (int p = 0; p < 4; p++)
        begin
            ex[0][2*p+1] = pin2[p];
            ex[0][2*p] = cq[p] & mode_in[p];
            for (int i = 0; i < msz[p]; i++)
            begin
                if (b < 40) ex[b] = pd[p][i];
                b++;
            end
            ex[40+p] = {stat[p][13:9], stat[p][8] | stat[p][7], stat[p].actual_pd_len > msz[p], stat[p][6]};
        end
    endtask
    task automatic frame(input logic s);
        int n, f0;
        n = 0;
        f0 = i_fb.frames;
        stall <= s;
        @(posedge clk) start <= 1'b1;
        @(posedge clk) start <= 1'b0;
        while (i_fb.frames == f0)
        begin
            if (++n > 400) tmo;
            @(posedge clk);
        end
        @(posedge clk);
        for (int k = 0; k < 44; k++) chk(i_fb.rx[k], ex[k]);
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        stat <= {14'h2602, 14'h2903, 14'h3082, 14'h2042};
        pin2 <= 4'ha;
        cq <= 4'hf;
        bus(0, REG_MAP, 0);
        chk(rword, 32'h02020202);
        bus(0, 5'h14, 0);
        chk(rword, 0);
        for (int p = 0; p < 4; p++)
            for (int i = 0; i < (p == 3 ? 32 : 4); i++)
            begin
                pd[p][i] = 8'(16 * p + i + 1);
                pdw(2'(p), 5'(i), pd[p][i]);
            end
        stat[0].input_valid_flag <= 1'b0;
        pdw(0, 0, 8'hee);
        mode_in = 4'h5;
        bus(1, REG_MODE, {28'h0, mode_in});
        msz = '{2, 2, 2, 2};
        build;
        frame(1);
        msz = '{4, 2, 2, 32};
        bus(1, REG_MAP, 32'h20020204);
        build;
        frame(0);
        bus(0, REG_PINS, 0);
        chk(rword, {24'h0, ex[0]});
        bus(0, REG_STATUS, 0);
        chk(rword, {ex[43], ex[42], ex[41], ex[40]});
        bus(0, REG_FRAMES, 0);
        chk(rword, 2);
        for (int k = 0; k < 44; k++) i_fb.tx[k] = 8'(3 * k + 1);
        i_fb.tx[0] = 8'hb1;
        bus(1, REG_MODE, 32'h000000f0);
        go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        for (int n = 0; n == 0 || ov_w !== 1'b0; n++)
        begin
            if (n > 100) tmo;
            @(posedge clk);
        end
        chk({cqe_w, cqo_w}, 8'hf5);
        for (int i = 0; i < 4; i++) opd(0, 5'(i), i_fb.tx[2+i]);
        opd(1, 0, i_fb.tx[6]);
        opd(3, 27, i_fb.tx[37]);
        bus(1, REG_MODE, 0);
        repeat (3) @(posedge clk);
        chk({cqe_w, cqo_w}, 8'h00);
        close_out;
    end
endmodule // test_io_link_master_io_image
